//--- core/otfr_pkg.sv
package otfr_pkg;
    localparam int          MANT_W           = 11;
    localparam int          CMD_W            = 8;
    localparam int          DATA_W           = 16;
    localparam int          TMR_W            = 20;
    // Command codes
    localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0]  CMD_STORE_ALL    = 8'h11;
    localparam logic [7:0]  CMD_RESTORE_ALL  = 8'h12;
    localparam logic [7:0]  CMD_OT_FAULT_THR = 8'h4F;
    localparam logic [7:0]  CMD_OT_FAULT_ACT = 8'h50;
    // Threshold values, in degrees per mantissa step
    localparam logic [10:0] THR_RESET        = 11'h091;
    localparam logic [10:0] THR_MIN          = 11'h078;
    localparam logic [10:0] THR_MAX          = 11'h0A5;
    localparam logic [10:0] THR_HYST         = 11'h014;
    localparam logic [4:0]  THR_EXPONENT     = 5'h00;
    // Action register layout and reset values
    localparam int          ACT_RSP_BIT      = 7;
    localparam int          ACT_RS_HI        = 5;
    localparam int          ACT_RS_LO        = 3;
    localparam logic        RSP_RESET        = 1'b0;
    localparam logic        RS_RESET         = 1'b1;
    localparam logic [2:0]  RS_NONE          = 3'h0;
    localparam logic [2:0]  RS_ALL           = 3'h7;
    // Retry delay timing
    localparam int          CLK_MHZ          = 40;
    localparam int          RAMP_TIME_US     = 1000;
    localparam int          RAMP_CYCLES      = RAMP_TIME_US * CLK_MHZ;
    localparam int          RETRY_RAMPS      = 7;
    localparam int          RETRY_DELAY_CYCLES = RETRY_RAMPS * RAMP_CYCLES;

    typedef enum logic [1:0] {
        OTFR_RUN,
        OTFR_COOL,
        OTFR_DELAY,
        OTFR_HELD
    } otfr_state_t;
endpackage : otfr_pkg

//--- core/otfr_nvm.sv
`timescale 1ns/1ps
module otfr_nvm
    import otfr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // Save request and live settings
    input  wire logic              save,
    input  wire logic [MANT_W-1:0] mant_in,
    input  wire logic              rsp_in,
    input  wire logic              rs_in,
    // Stored settings
    output logic      [MANT_W-1:0] mant_out,
    output logic                   rsp_out,
    output logic                   rs_out
);
    logic [MANT_W-1:0] mant_reg;
    logic              rsp_reg;
    logic              rs_reg;

    // Store image; only one retry bit kept since the field is all-equal
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mant_reg <= THR_RESET;
            rsp_reg  <= RSP_RESET;
            rs_reg   <= RS_RESET;
        end else if (ce && save) begin
            mant_reg <= mant_in;
            rsp_reg  <= rsp_in;
            rs_reg   <= rs_in;
        end
    end

    assign mant_out = mant_reg;
    assign rsp_out  = rsp_reg;
    assign rs_out   = rs_reg;

    property p_save;
        @(posedge mclk) disable iff (sys_rst)
        (ce && save) |=> (mant_reg == $past(mant_in))
                         && (rs_reg == $past(rs_in));
    endproperty
    a_save: assert property (p_save)
        else $error("store image not updated on save");
endmodule : otfr_nvm

//--- core/otfr_retry_timer.sv
`timescale 1ns/1ps
module otfr_retry_timer
    import otfr_pkg::*;
#(
    parameter int CYCLES = RETRY_DELAY_CYCLES
)(
    // Clock, reset, enable
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // Start pulse and expiry pulse
    input  wire logic start,
    output logic      done
);
    logic [TMR_W-1:0] cnt_reg;
    logic             busy_reg;
    logic             done_reg;

    // Counts the restart delay; a new start reloads a running count
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce) begin
            done_reg <= 1'b0;
            if (start) begin
                cnt_reg  <= '0;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (cnt_reg == TMR_W'(CYCLES - 1)) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end

    assign done = done_reg;

    property p_done_cause;
        @(posedge mclk) disable iff (sys_rst)
        $rose(done_reg) |-> $past(busy_reg) && !busy_reg;
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("delay expiry without a running count");
endmodule : otfr_retry_timer

//--- core/otfr_core.sv
`timescale 1ns/1ps
module otfr_core
    import otfr_pkg::*;
#(
    parameter int RETRY_DELAY = RETRY_DELAY_CYCLES
)(
    // Clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // Command port
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [CMD_W-1:0]  cmd_code,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    output logic      [DATA_W-1:0] cmd_rdata,
    output logic                   cmd_rvalid,
    // Sensing and neighbouring settings
    input  wire logic [MANT_W-1:0] temp_c,
    input  wire logic [MANT_W-1:0] overtemp_warning_threshold,
    input  wire logic              bandgap_ot,
    input  wire logic              alert_mask_ot,
    input  wire logic              alert_mask_cml,
    // Status and alert
    output logic                   overtemp_summary_flag,
    output logic                   overtemp_fault_flag,
    output logic                   comm_fault_flag,
    output logic                   invalid_data_flag,
    output logic                   smbalert_n,
    // Power stage control
    output logic                   power_enable,
    output logic                   soft_start
);
    logic [MANT_W-1:0] thr_reg;
    logic              rsp_reg;
    logic              rs_reg;
    logic              ot_latch_reg;
    logic              cml_reg;
    logic              ivd_reg;
    logic              smbalert_n_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic              rvalid_reg;
    logic              power_reg;
    logic              ss_reg;
    otfr_state_t       state_reg;

    logic [MANT_W-1:0] nvm_mant;
    logic              nvm_rsp;
    logic              nvm_rs;
    logic              tmr_done;

    // Command decode
    logic              is_wr;
    logic              wr_thr;
    logic              wr_act;
    logic              do_clear;
    logic              do_store;
    logic              do_restore;
    logic              rd_req;
    logic [MANT_W-1:0] new_mant;
    logic [2:0]        new_rs;
    logic              thr_bad;
    logic              act_bad;
    logic              reject;
    logic [7:0]        act_byte;
    logic [MANT_W-1:0] thr_low;
    logic              hot;
    logic              trip;
    logic              tmr_start;

    assign is_wr      = cmd_valid && cmd_write;
    assign rd_req     = cmd_valid && !cmd_write;
    assign wr_thr     = is_wr && (cmd_code == CMD_OT_FAULT_THR);
    assign wr_act     = is_wr && (cmd_code == CMD_OT_FAULT_ACT);
    assign do_clear   = is_wr && (cmd_code == CMD_CLEAR_FAULTS);
    assign do_store   = is_wr && (cmd_code == CMD_STORE_ALL);
    assign do_restore = is_wr && (cmd_code == CMD_RESTORE_ALL);
    // Exponent bits of the written word are dropped
    assign new_mant   = cmd_wdata[MANT_W-1:0];
    assign new_rs     = cmd_wdata[ACT_RS_HI:ACT_RS_LO];

    // Validity of written values
    assign thr_bad = (new_mant <= overtemp_warning_threshold)
                   || (new_mant < THR_MIN)
                   || (new_mant > THR_MAX);
    assign act_bad = (new_rs != RS_NONE) && (new_rs != RS_ALL);
    assign reject  = (wr_thr && thr_bad) || (wr_act && act_bad);

    // Read image: bit 6 zero, retry and delay bits rebuilt from one bit
    assign act_byte = {rsp_reg, 1'b0, {3{rs_reg}}, {3{rs_reg}}};
    assign thr_low  = thr_reg - THR_HYST;
    assign hot      = ot_latch_reg || bandgap_ot;
    // Bandgap faults bypass the ignore selection
    assign trip     = (ot_latch_reg && rsp_reg) || bandgap_ot;
    assign tmr_start = (state_reg == OTFR_COOL) && !hot;

    // Fault threshold register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            thr_reg <= THR_RESET;
        end else if (ce) begin
            if (do_restore) begin
                thr_reg <= nvm_mant;
            end else if (wr_thr && !thr_bad) begin
                thr_reg <= new_mant;
            end
        end
    end

    // Fault action register; a rejected write changes nothing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rsp_reg <= RSP_RESET;
            rs_reg  <= RS_RESET;
        end else if (ce) begin
            if (do_restore) begin
                rsp_reg <= nvm_rsp;
                rs_reg  <= nvm_rs;
            end else if (wr_act && !act_bad) begin
                rsp_reg <= cmd_wdata[ACT_RSP_BIT];
                rs_reg  <= cmd_wdata[ACT_RS_HI];
            end
        end
    end

    // Overtemperature latch with hysteresis below the threshold
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ot_latch_reg <= 1'b0;
        end else if (ce) begin
            if (temp_c > thr_reg) begin
                ot_latch_reg <= 1'b1;
            end else if (temp_c <= thr_low) begin
                ot_latch_reg <= 1'b0;
            end
        end
    end

    // Communication flags; a rejection in the clear cycle still sets them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cml_reg <= 1'b0;
            ivd_reg <= 1'b0;
        end else if (ce) begin
            if (reject) begin
                cml_reg <= 1'b1;
                ivd_reg <= 1'b1;
            end else if (do_clear) begin
                cml_reg <= 1'b0;
                ivd_reg <= 1'b0;
            end
        end
    end

    // Alert line, active low, follows flags whatever the response mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            smbalert_n_reg <= 1'b1;
        end else if (ce) begin
            smbalert_n_reg <= !((ot_latch_reg && !alert_mask_ot)
                              || (cml_reg && !alert_mask_cml));
        end
    end

    // Read answers one cycle after the request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rvalid_reg <= rd_req;
            if (rd_req) begin
                unique case (cmd_code)
                    CMD_OT_FAULT_THR: rdata_reg <= {THR_EXPONENT, thr_reg};
                    CMD_OT_FAULT_ACT: rdata_reg <= {8'h00, act_byte};
                    default:          rdata_reg <= '0;
                endcase
            end
        end
    end

    // Shutdown and restart sequencing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= OTFR_RUN;
            power_reg <= 1'b1;
            ss_reg    <= 1'b0;
        end else if (ce) begin
            ss_reg <= 1'b0;
            unique case (state_reg)
                OTFR_RUN: begin
                    if (trip) begin
                        power_reg <= 1'b0;
                        // Retry choice also covers bandgap faults
                        state_reg <= rs_reg ? OTFR_COOL : OTFR_HELD;
                    end
                end
                OTFR_COOL: begin
                    if (!hot) begin
                        state_reg <= OTFR_DELAY;
                    end
                end
                OTFR_DELAY: begin
                    if (tmr_done) begin
                        state_reg <= OTFR_RUN;
                        power_reg <= 1'b1;
                        ss_reg    <= 1'b1;
                    end
                end
                OTFR_HELD: begin
                    // Stays off until faults are cleared and part is cool
                    if (do_clear && !hot) begin
                        state_reg <= OTFR_RUN;
                        power_reg <= 1'b1;
                        ss_reg    <= 1'b1;
                    end
                end
            endcase
        end
    end

    otfr_nvm u_nvm (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .save     (do_store),
        .mant_in  (thr_reg),
        .rsp_in   (rsp_reg),
        .rs_in    (rs_reg),
        .mant_out (nvm_mant),
        .rsp_out  (nvm_rsp),
        .rs_out   (nvm_rs)
    );

    otfr_retry_timer #(
        .CYCLES (RETRY_DELAY)
    ) u_timer (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .start   (tmr_start),
        .done    (tmr_done)
    );

    assign cmd_rdata             = rdata_reg;
    assign cmd_rvalid            = rvalid_reg;
    assign overtemp_summary_flag = ot_latch_reg;
    assign overtemp_fault_flag   = ot_latch_reg;
    assign comm_fault_flag       = cml_reg;
    assign invalid_data_flag     = ivd_reg;
    assign smbalert_n            = smbalert_n_reg;
    assign power_enable          = power_reg;
    assign soft_start            = ss_reg;

    property p_trip;
        @(posedge mclk) disable iff (sys_rst)
        (ce && temp_c > thr_reg) |=> ot_latch_reg;
    endproperty
    a_trip: assert property (p_trip)
        else $error("fault not latched above threshold");

    property p_hyst;
        @(posedge mclk) disable iff (sys_rst)
        $fell(ot_latch_reg) |-> $past(temp_c) <= $past(thr_low);
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("fault released before hysteresis point");

    property p_warn_rej;
        @(posedge mclk) disable iff (sys_rst)
        (ce && wr_thr && new_mant <= overtemp_warning_threshold)
            |=> cml_reg && ivd_reg && $stable(thr_reg);
    endproperty
    a_warn_rej: assert property (p_warn_rej)
        else $error("threshold write at or below warning accepted");

    property p_range;
        @(posedge mclk) disable iff (sys_rst)
        1'b1 |-> (thr_reg >= THR_MIN) && (thr_reg <= THR_MAX);
    endproperty
    a_range: assert property (p_range)
        else $error("threshold outside allowed range");

    property p_rs_rej;
        @(posedge mclk) disable iff (sys_rst)
        (ce && wr_act && act_bad && !do_restore)
            |=> ivd_reg && $stable(rs_reg) && $stable(rsp_reg);
    endproperty
    a_rs_rej: assert property (p_rs_rej)
        else $error("mixed retry field accepted");

    property p_alert;
        @(posedge mclk) disable iff (sys_rst)
        (ce && ot_latch_reg && !alert_mask_ot) |=> !smbalert_n_reg;
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert missing on fault");

    property p_ignore;
        @(posedge mclk) disable iff (sys_rst)
        (ce && state_reg == OTFR_RUN && power_reg && !rsp_reg && !bandgap_ot)
            |=> power_reg;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("ignore mode shut the output down");

    property p_bandgap;
        @(posedge mclk) disable iff (sys_rst)
        (ce && state_reg == OTFR_RUN && bandgap_ot) |=> !power_reg;
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("bandgap fault did not shut down");

    property p_mirror;
        @(posedge mclk) disable iff (sys_rst)
        (ce && rd_req && cmd_code == CMD_OT_FAULT_ACT)
            |=> (rdata_reg[2:0] == {3{rdata_reg[5]}}) && !rdata_reg[6];
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("delay bits do not mirror retry bit");

    c_trip:    cover property (@(posedge mclk) $rose(ot_latch_reg));
    c_restart: cover property (@(posedge mclk) ss_reg);
    c_reject:  cover property (@(posedge mclk) $rose(ivd_reg));
    c_held:    cover property (@(posedge mclk) state_reg == OTFR_HELD);
endmodule : otfr_core

//--- tb/otfr_host.sv
`timescale 1ns/1ps
module otfr_host
    import otfr_pkg::*;
(
    // Clock and answer from the device
    input  wire logic              mclk,
    input  wire logic [DATA_W-1:0] cmd_rdata,
    input  wire logic              cmd_rvalid,
    // Request lines toward the device
    output logic                   cmd_valid,
    output logic                   cmd_write,
    output logic      [CMD_W-1:0]  cmd_code,
    output logic      [DATA_W-1:0] cmd_wdata
);
    // Idle request lines at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'hA5A5;
    end

    // One-cycle strobe; data flips after release so stale data never helps
    task automatic send(input logic wr, input logic [7:0] code,
                        input logic [15:0] data);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_wdata <= data;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~data;
    endtask : send

    // Read answer is taken at the edge after the request is accepted
    task automatic fetch(input logic [7:0] code, output logic [15:0] data,
                         output logic ok);
        send(1'b0, code, 16'h0000);
        @(posedge mclk);
        ok   = cmd_rvalid;
        data = cmd_rdata;
    endtask : fetch
endmodule : otfr_host

//--- tb/overtemp_fault_limit_response_test.sv
`timescale 1ns/1ps
// Compare helper: counts every check and reports a mismatch at once
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  error_cnt++; $display("wrong value %s exp %0h got %0h", nm, ex, got); \
  end end
module overtemp_fault_limit_response_test;
    import otfr_pkg::*;
    localparam int RD = 20;
    // Design signals
    logic              mclk, sys_rst, ce, cmd_valid, cmd_write, cmd_rvalid;
    logic [CMD_W-1:0]  cmd_code;
    logic [DATA_W-1:0] cmd_wdata, cmd_rdata;
    logic [MANT_W-1:0] temp_c, warn;
    logic              bandgap_ot, mask_ot, mask_cml, sum_flag, ot_flag;
    logic              cml_flag, ivd_flag, smbalert_n, power_enable;
    logic              soft_start;
    // Bench model state, including the stored image
    int                error_cnt = 0, n_tests = 0, seed = 32'hee001623;
    int                thr_m = 145, s_thr = 145;
    logic              rsp_m = 1'b0, rs_m = 1'b1, s_rsp = 1'b0, s_rs = 1'b1;
    logic              cml_m = 1'b0, ot_m = 1'b0;

    otfr_core #(.RETRY_DELAY(RD)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .ce(ce), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .temp_c(temp_c),
        .overtemp_warning_threshold(warn), .bandgap_ot(bandgap_ot),
        .alert_mask_ot(mask_ot), .alert_mask_cml(mask_cml),
        .overtemp_summary_flag(sum_flag), .overtemp_fault_flag(ot_flag),
        .comm_fault_flag(cml_flag), .invalid_data_flag(ivd_flag),
        .smbalert_n(smbalert_n), .power_enable(power_enable),
        .soft_start(soft_start));
    otfr_host u_host (.mclk(mclk), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] ex);
        logic [15:0] d;
        logic        ok;
        u_host.fetch(code, d, ok);
        `CHK("read strobe", 1'b1, ok)
        `CHK("read data", ex, d)
    endtask : rd_chk

    // Status and alert against the model; alert is low when any set source
    // is unmasked
    task automatic chk_flags;
        logic al;
        al = ~((cml_m & ~mask_cml) | (ot_m & ~mask_ot));
        `CHK("comm fault", cml_m, cml_flag)
        `CHK("invalid data", cml_m, ivd_flag)
        `CHK("fault flag", ot_m, ot_flag)
        `CHK("summary flag", ot_m, sum_flag)
        `CHK("alert", al, smbalert_n)
    endtask : chk_flags

    task automatic clr;
        u_host.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
        cml_m = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : clr

    // Threshold write with a random exponent that must be dropped
    task automatic put_thr(input int m);
        logic [4:0] e;
        e = 5'($random(seed));
        u_host.send(1'b1, CMD_OT_FAULT_THR, {e, 11'(m)});
        // Judged after the strobe edge, once a new warning level has landed
        if (m > int'(warn) && m >= 120 && m <= 165)
            thr_m = m;
        else
            cml_m = 1'b1;
        rd_chk(CMD_OT_FAULT_THR, 16'(thr_m));
        chk_flags();
    endtask : put_thr

    task automatic put_act(input logic [7:0] d);
        if (d[5:3] == RS_NONE || d[5:3] == RS_ALL) begin
            rsp_m = d[ACT_RSP_BIT];
            rs_m  = d[ACT_RS_HI];
        end else begin
            cml_m = 1'b1;
        end
        u_host.send(1'b1, CMD_OT_FAULT_ACT, {8'h00, d});
        rd_chk(CMD_OT_FAULT_ACT, {8'h00, rsp_m, 1'b0, {6{rs_m}}});
        chk_flags();
    endtask : put_act

    // Latch sets above threshold and drops only 20 degrees below it
    task automatic set_temp(input int t, input logic pe);
        @(posedge mclk);
        temp_c <= 11'(t);
        if (t > thr_m)
            ot_m = 1'b1;
        else if (t <= thr_m - 20)
            ot_m = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk_flags();
        `CHK("power_enable", pe, power_enable)
    endtask : set_temp

    // Bounded wait for the restart pulse after the cause has gone
    task automatic wait_restart;
        int n;
        n = 0;
        while (soft_start !== 1'b1 && n < RD + 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("restart delay", 1'b1, n >= RD && n <= RD + 4)
        `CHK("restart power", 1'b1, power_enable)
        if (n >= RD + 50)
            wrap_up();
    endtask : wait_restart

    // Without retry the output waits for a clear command
    task automatic held_then_clear;
        repeat (3 * RD) @(posedge mclk);
        #1;
        `CHK("held off", 1'b0, power_enable)
        clr();
        `CHK("power after clear", 1'b1, power_enable)
    endtask : held_then_clear

    // Main sequence
    initial begin
        int lst[7] = '{119, 120, 125, 126, 165, 166, 140};
        sys_rst    = 1'b1;
        ce         = 1'b1;
        temp_c     = 11'd25;
        warn       = 11'd125;
        bandgap_ot = 1'b0;
        mask_ot    = 1'b0;
        mask_cml   = 1'b0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_chk(CMD_OT_FAULT_THR, 16'h0091);
        rd_chk(CMD_OT_FAULT_ACT, 16'h003F);
        chk_flags();
        `CHK("power_enable", 1'b1, power_enable)
        $display("test reset done");
        foreach (lst[i]) put_thr(lst[i]);
        repeat (12) put_thr(110 + ($random(seed) & 63));
        clr();
        @(posedge mclk);
        warn <= 11'd140;
        put_thr(140);
        put_thr(141);
        warn <= 11'd125;
        clr();
        chk_flags();
        $display("test threshold done");
        // Masked comm fault keeps the alert line high
        mask_cml <= 1'b1;
        put_thr(100);
        mask_cml <= 1'b0;
        clr();
        // A write while the clock enable is low must be dropped
        @(posedge mclk);
        ce <= 1'b0;
        u_host.send(1'b1, CMD_OT_FAULT_THR, 16'h009B);
        ce <= 1'b1;
        rd_chk(CMD_OT_FAULT_THR, 16'(thr_m));
        $display("test mask and enable done");
        for (int r = 0; r < 8; r++)
            put_act({8'($random(seed))} & 8'hC7 | 8'(r << 3));
        clr();
        $display("test action done");
        put_thr(150);
        put_act(8'h80);
        u_host.send(1'b1, CMD_STORE_ALL, 16'h0000);
        {s_thr, s_rsp, s_rs} = {thr_m, rsp_m, rs_m};
        put_thr(130);
        put_act(8'h38);
        u_host.send(1'b1, CMD_RESTORE_ALL, 16'h0000);
        {thr_m, rsp_m, rs_m} = {s_thr, s_rsp, s_rs};
        rd_chk(CMD_OT_FAULT_THR, 16'(thr_m));
        rd_chk(CMD_OT_FAULT_ACT, {8'h00, rsp_m, 1'b0, {6{rs_m}}});
        $display("test store done");
        put_thr(140);
        put_act(8'h38);
        set_temp(140, 1'b1);
        set_temp(141, 1'b1);
        set_temp(121, 1'b1);
        set_temp(120, 1'b1);
        mask_ot <= 1'b1;
        set_temp(150, 1'b1);
        mask_ot <= 1'b0;
        set_temp(100, 1'b1);
        $display("test ignore done");
        put_act(8'hB8);
        set_temp(150, 1'b0);
        @(posedge mclk);
        temp_c <= 11'd100;
        ot_m = 1'b0;
        wait_restart();
        put_act(8'h80);
        set_temp(150, 1'b0);
        set_temp(100, 1'b0);
        held_then_clear();
        $display("test shutdown done");
        put_act(8'h38);
        @(posedge mclk);
        bandgap_ot <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `CHK("bandgap off", 1'b0, power_enable)
        @(posedge mclk);
        bandgap_ot <= 1'b0;
        wait_restart();
        put_act(8'h00);
        @(posedge mclk);
        bandgap_ot <= 1'b1;
        repeat (3) @(posedge mclk);
        bandgap_ot <= 1'b0;
        held_then_clear();
        $display("test bandgap done");
        wrap_up();
    end
endmodule : overtemp_fault_limit_response_test
